// ===== core/fwsr_pkg.sv
package fwsr_pkg;

    // -----------------------------------------------------------------
    // flash bus geometry
    // -----------------------------------------------------------------
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;

    // -----------------------------------------------------------------
    // status word bit positions
    // -----------------------------------------------------------------
    localparam int BIT_DATA_POLL    = 7;
    localparam int BIT_TOGGLE_ONE   = 6;
    localparam int BIT_TIMEOUT_FLAG = 5;
    localparam int BIT_ERASE_TIMER  = 3;
    localparam int BIT_TOGGLE_TWO   = 2;
    localparam int BIT_BUFFER_ABORT = 1;

    // -----------------------------------------------------------------
    // bus cycle timing
    // -----------------------------------------------------------------
    localparam int CLK_MHZ  = 40;
    localparam int T_RD_NS  = 70;
    localparam int T_WP_NS  = 45;
    localparam int T_REC_NS = 30;
    localparam int CYC_RD   = (T_RD_NS * CLK_MHZ + 999) / 1000;
    localparam int CYC_WP   = (T_WP_NS * CLK_MHZ + 999) / 1000;
    localparam int CYC_REC  = (T_REC_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W    = 4;

    // -----------------------------------------------------------------
    // register map (byte offsets)
    // -----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_ADDR     = 8'h04;
    localparam logic [7:0] OFS_WDATA    = 8'h08;
    localparam logic [7:0] OFS_RDATA    = 8'h0C;
    localparam logic [7:0] OFS_STATE    = 8'h10;
    localparam logic [7:0] OFS_INT_STAT = 8'h14;
    localparam logic [7:0] OFS_INT_MASK = 8'h18;

    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_FAST   = 8;

    // interrupt status bits
    localparam int NUM_EV       = 5;
    localparam int EV_DONE      = 0;
    localparam int EV_FAIL      = 1;
    localparam int EV_BUF_ABORT = 2;
    localparam int EV_REJECTED  = 3;
    localparam int EV_STARTED   = 4;

    // -----------------------------------------------------------------
    // operations
    // -----------------------------------------------------------------
    localparam logic [2:0] OP_WRITE     = 3'h0;
    localparam logic [2:0] OP_READ      = 3'h1;
    localparam logic [2:0] OP_POLL      = 3'h2;
    localparam logic [2:0] OP_ACCEPT    = 3'h3;
    localparam logic [2:0] OP_SECT_ADD  = 3'h4;
    localparam logic [2:0] OP_ABORT_RST = 3'h5;

    typedef enum logic [2:0] {
        FWSR_IDLE,
        FWSR_NEXT,
        FWSR_RD,
        FWSR_WR,
        FWSR_REC
    } fwsr_state_e;

endpackage

// ===== core/fwsr_ctrl.sv
// Summary of operation
// - fast adds under 50 us skip timer checks
// - confirm acceptance by toggle before reading timer
// - check timer before and after each added sector
// - abort needs dedicated abort reset sequence
// - status reads must use valid operation address
// - buffer polling at last loaded buffer address
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/10ps
module fwsr_ctrl
    import fwsr_pkg::*;
#(
    parameter logic [ADDR_W-1:0] UNLOCK_ADDR_A = 20'h0_0555,
    parameter logic [ADDR_W-1:0] UNLOCK_ADDR_B = 20'h0_02AA,
    parameter logic [DATA_W-1:0] UNLOCK_DATA_A = 16'h0_0AA,
    parameter logic [DATA_W-1:0] UNLOCK_DATA_B = 16'h0_055,
    parameter logic [DATA_W-1:0] ABORT_RST_CMD = 16'h0_0F0
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    output logic                   irq,
    output logic [ADDR_W-1:0]      flash_addr,
    input  wire logic [DATA_W-1:0] flash_dq_in,
    output logic [DATA_W-1:0]      flash_dq_out,
    output logic                   flash_dq_oe,
    output logic                   flash_ce_n,
    output logic                   flash_oe_n,
    output logic                   flash_we_n,
    input  wire logic              ready_busy_n
);

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    typedef struct packed {
        fwsr_state_e       st;
        logic [CNT_W-1:0]  cnt;
        logic [2:0]        step;
        logic [2:0]        op;
        logic              fast;
        logic              recheck;
        logic              tb2_toggled;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic [DATA_W-1:0] prev;
        logic [NUM_EV-1:0] int_st;
        logic [NUM_EV-1:0] int_mask;
        logic              pready;
        logic [31:0]       prdata;
        logic              pslverr;
        logic              irq;
        logic [ADDR_W-1:0] f_addr;
        logic [DATA_W-1:0] f_dq;
        logic              f_oe;
        logic              f_ce_n;
        logic              f_oe_n;
        logic              f_we_n;
    } fwsr_regs_s;

    fwsr_regs_s r;
    fwsr_regs_s next_r;

    logic [NUM_EV-1:0] ev;
    logic [NUM_EV-1:0] clr;
    logic              tb1_same;
    logic              tb2_same;
    logic              apb_wr;

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    always_comb begin
        next_r   = r;
        ev       = '0;
        clr      = '0;
        tb1_same = (r.rdata[BIT_TOGGLE_ONE] == r.prev[BIT_TOGGLE_ONE]);
        tb2_same = (r.rdata[BIT_TOGGLE_TWO] == r.prev[BIT_TOGGLE_TWO]);
        apb_wr   = psel && penable && r.pready && pwrite;

        // apb slave: one wait state, answer registered
        next_r.pready  = 1'b0;
        next_r.pslverr = 1'b0;
        if (psel && penable && !r.pready) begin
            next_r.pready = 1'b1;
            next_r.prdata = '0;
            case (paddr)
                OFS_CTRL:     next_r.prdata = {23'h00_0000, r.fast, 5'h00, r.op};
                OFS_ADDR:     next_r.prdata = {12'h000, r.addr};
                OFS_WDATA:    next_r.prdata = {16'h0000, r.wdata};
                OFS_RDATA:    next_r.prdata = {16'h0000, r.rdata};
                OFS_STATE:    next_r.prdata = {29'h0000_0000, r.tb2_toggled,
                                               ready_busy_n, (r.st != FWSR_IDLE)};
                OFS_INT_STAT: next_r.prdata = {27'h000_0000, r.int_st};
                OFS_INT_MASK: next_r.prdata = {27'h000_0000, r.int_mask};
                default:      next_r.pslverr = 1'b1;
            endcase
        end

        if (apb_wr) begin
            case (paddr)
                OFS_ADDR:     next_r.addr = pwdata[ADDR_W-1:0];
                OFS_WDATA:    next_r.wdata = pwdata[DATA_W-1:0];
                OFS_INT_STAT: clr = pwdata[NUM_EV-1:0];
                OFS_INT_MASK: next_r.int_mask = pwdata[NUM_EV-1:0];
                OFS_CTRL: begin
                    // a start while busy is dropped: the flash is mid-cycle
                    if (r.st == FWSR_IDLE) begin
                        next_r.op      = pwdata[CTRL_OP_LSB+2:CTRL_OP_LSB];
                        next_r.fast    = pwdata[CTRL_FAST];
                        next_r.step    = '0;
                        next_r.recheck = 1'b0;
                        next_r.st      = FWSR_NEXT;
                    end
                end
                default: ;
            endcase
        end

        case (r.st)
            FWSR_IDLE: ;

            FWSR_NEXT: begin
                next_r.st = FWSR_RD;
                next_r.f_addr = r.addr;
                next_r.cnt = CNT_W'(CYC_RD);
                next_r.step = r.step + 3'h1;
                case (r.op)
                    OP_WRITE: begin
                        if (r.step == 3'h0) begin
                            next_r.st   = FWSR_WR;
                            next_r.f_dq = r.wdata;
                            next_r.cnt  = CNT_W'(CYC_WP);
                        end else begin
                            next_r.st = FWSR_IDLE;
                            ev[EV_DONE] = 1'b1;
                        end
                    end
                    OP_READ: begin
                        if (r.step != 3'h0) begin
                            next_r.st = FWSR_IDLE;
                            ev[EV_DONE] = 1'b1;
                        end
                    end
                    OP_POLL: begin
                        // two reads in a row before judging the toggle; the first seeds prev
                        next_r.prev = r.rdata;
                        next_r.step = (r.step == 3'h0) ? 3'h1 : 3'h2;
                        if (r.step == 3'h2) begin
                            next_r.tb2_toggled = !tb2_same;
                            if (tb1_same) begin
                                next_r.st = FWSR_IDLE;
                                ev[EV_DONE] = 1'b1;
                            end else if (r.recheck) begin
                                next_r.st = FWSR_IDLE;
                                ev[EV_FAIL] = 1'b1;
                            end else if (r.rdata[BIT_BUFFER_ABORT]) begin
                                next_r.st = FWSR_IDLE;
                                ev[EV_BUF_ABORT] = 1'b1;
                            end else if (r.rdata[BIT_TIMEOUT_FLAG]) begin
                                // toggle may stop just as the flag rises
                                next_r.recheck = 1'b1;
                            end
                        end
                    end
                    OP_ACCEPT: begin
                        // acceptance first, the third read then carries the timer
                        if (r.step == 3'h1) begin
                            next_r.prev = r.rdata;
                        end else if (r.step == 3'h2) begin
                            if (tb1_same) begin
                                next_r.st = FWSR_IDLE;
                                ev[EV_REJECTED] = 1'b1;
                            end
                        end else if (r.step == 3'h3) begin
                            next_r.st = FWSR_IDLE;
                            ev[EV_DONE] = 1'b1;
                            ev[EV_STARTED] = r.rdata[BIT_ERASE_TIMER];
                        end
                    end
                    OP_SECT_ADD: begin
                        if (r.step == 3'h0 && r.fast) begin
                            next_r.step = 3'h2;
                            next_r.st   = FWSR_WR;
                            next_r.f_dq = r.wdata;
                            next_r.cnt  = CNT_W'(CYC_WP);
                        end else if (r.step == 3'h1) begin
                            if (r.rdata[BIT_ERASE_TIMER]) begin
                                // erase already running: the add would be ignored
                                next_r.st = FWSR_IDLE;
                                ev[EV_STARTED] = 1'b1;
                            end else begin
                                next_r.st   = FWSR_WR;
                                next_r.f_dq = r.wdata;
                                next_r.cnt  = CNT_W'(CYC_WP);
                            end
                        end else if (r.step == 3'h2 && r.fast) begin
                            next_r.st = FWSR_IDLE;
                            ev[EV_DONE] = 1'b1;
                        end else if (r.step == 3'h3) begin
                            next_r.st = FWSR_IDLE;
                            ev[EV_DONE] = 1'b1;
                            ev[EV_REJECTED] = r.rdata[BIT_ERASE_TIMER];
                        end
                    end
                    OP_ABORT_RST: begin
                        next_r.st  = FWSR_WR;
                        next_r.cnt = CNT_W'(CYC_WP);
                        case (r.step)
                            3'h0: begin
                                next_r.f_addr = UNLOCK_ADDR_A;
                                next_r.f_dq   = UNLOCK_DATA_A;
                            end
                            3'h1: begin
                                next_r.f_addr = UNLOCK_ADDR_B;
                                next_r.f_dq   = UNLOCK_DATA_B;
                            end
                            3'h2: begin
                                next_r.f_addr = UNLOCK_ADDR_A;
                                next_r.f_dq   = ABORT_RST_CMD;
                            end
                            default: begin
                                next_r.st = FWSR_IDLE;
                                ev[EV_DONE] = 1'b1;
                            end
                        endcase
                    end
                    default: begin
                        next_r.st = FWSR_IDLE;
                        ev[EV_FAIL] = 1'b1;
                    end
                endcase
                if (next_r.st == FWSR_RD) begin
                    next_r.f_ce_n = 1'b0;
                    next_r.f_oe_n = 1'b0;
                end
                if (next_r.st == FWSR_WR) begin
                    next_r.f_ce_n = 1'b0;
                    next_r.f_we_n = 1'b0;
                    next_r.f_oe   = 1'b1;
                end
            end

            FWSR_RD: begin
                next_r.cnt = r.cnt - CNT_W'(1);
                if (r.cnt == CNT_W'(1)) begin
                    next_r.rdata  = flash_dq_in;
                    next_r.f_ce_n = 1'b1;
                    next_r.f_oe_n = 1'b1;
                    next_r.cnt    = CNT_W'(CYC_REC);
                    next_r.st     = FWSR_REC;
                end
            end

            FWSR_WR: begin
                next_r.cnt = r.cnt - CNT_W'(1);
                if (r.cnt == CNT_W'(1)) begin
                    // data held through recovery, released afterwards
                    next_r.f_ce_n = 1'b1;
                    next_r.f_we_n = 1'b1;
                    next_r.cnt    = CNT_W'(CYC_REC);
                    next_r.st     = FWSR_REC;
                end
            end

            FWSR_REC: begin
                next_r.cnt = r.cnt - CNT_W'(1);
                if (r.cnt == CNT_W'(1)) begin
                    next_r.f_oe = 1'b0;
                    next_r.st   = FWSR_NEXT;
                end
            end

            default: next_r.st = FWSR_IDLE;
        endcase

        // a new event wins over a clear in the same cycle
        next_r.int_st = (r.int_st & ~clr) | ev;
        next_r.irq    = |(next_r.int_st & next_r.int_mask);
    end

    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r        <= '0;
            r.st     <= FWSR_IDLE;
            r.f_ce_n <= 1'b1;
            r.f_oe_n <= 1'b1;
            r.f_we_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign pready       = r.pready;
    assign prdata       = r.prdata;
    assign pslverr      = r.pslverr;
    assign irq          = r.irq;
    assign flash_addr   = r.f_addr;
    assign flash_dq_out = r.f_dq;
    assign flash_dq_oe  = r.f_oe;
    assign flash_ce_n   = r.f_ce_n;
    assign flash_oe_n   = r.f_oe_n;
    assign flash_we_n   = r.f_we_n;

endmodule // fwsr_ctrl

// ===== testbench/fwsr_props.sv
`timescale 1ns/10ps
module fwsr_props
    import fwsr_pkg::*;
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              irq,
    input wire logic [ADDR_W-1:0] flash_addr,
    input wire logic [DATA_W-1:0] flash_dq_out,
    input wire logic              flash_dq_oe,
    input wire logic              flash_ce_n,
    input wire logic              flash_oe_n,
    input wire logic              flash_we_n
);
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------
    // bus answer and flash strobe timing
    // ------------------------------------------------------------
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready not one wait state after access");
    a_slverr_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_irq_unmask: assert property (pready && pwrite && paddr == OFS_INT_MASK && pwdata == '0
        |=> !irq) else $error("irq stays high with all sources masked");
    // status reads hold the strobe long enough to settle
    a_read_strobe: assert property ($fell(flash_oe_n) |-> !flash_oe_n[*3] ##[1:2] flash_oe_n)
        else $error("flash read strobe length wrong");
    a_write_hold: assert property ($fell(flash_we_n) |-> flash_dq_oe && !flash_ce_n
        ##1 (flash_dq_oe && $stable(flash_dq_out))[*2]) else $error("write data not held");
    a_addr_stable: assert property (!flash_oe_n && $past(!flash_oe_n) |-> $stable(flash_addr))
        else $error("address moved during a read");
    a_read_nodrive: assert property (!flash_oe_n |-> !flash_dq_oe)
        else $error("controller drives dq during a read");
    a_ce_strobe: assert property (!flash_oe_n || !flash_we_n |-> !flash_ce_n)
        else $error("strobe without chip enable");
    c_read: cover property ($fell(flash_oe_n));
    c_write: cover property ($fell(flash_we_n));
    c_irq: cover property ($rose(irq));
endmodule // fwsr_props

bind fwsr_ctrl fwsr_props fwsr_props_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
    .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n)
);

// ===== testbench/fwsr_flash_model.sv
`timescale 1ns/10ps
module fwsr_flash_model
    import fwsr_pkg::*;
(
    input  wire logic [ADDR_W-1:0] flash_addr,
    input  wire logic [DATA_W-1:0] flash_dq_out,
    input  wire logic              flash_ce_n,
    input  wire logic              flash_oe_n,
    input  wire logic              flash_we_n,
    input  wire logic              cfg_abort,
    input  wire logic              cfg_tout,
    output logic [DATA_W-1:0]      flash_dq_in,
    output logic                   ready_busy_n
);
    localparam int BUSY_RD = 4;
    localparam int WIN_RD  = 6;
    logic [DATA_W-1:0] last_wr = '0;
    logic [DATA_W-1:0] rd_word = '0;
    logic [3:0]        sect    = '0;
    logic              erase   = 0, t1 = 0, t2 = 0, abort = 0, tout = 0;
    logic              susp    = 0, armed = 0;
    int                busy    = 0, win = 0;
    logic              is_unl;
    assign is_unl = flash_dq_out == 16'h00AA || flash_dq_out == 16'h0055;
    // the strobe rising out of reset is no write: only a pulse seen to fall counts
    always @(negedge flash_we_n) armed = 1;
    // a command word is taken when the write strobe ends
    always @(posedge flash_we_n) begin
        if (!armed) begin
        end else if (flash_dq_out == 16'h00F0) begin
            busy = 0; abort = 0; tout = 0; erase = 0;
            susp = 0;
        end else if (erase && win == 0 && busy > 0) begin
            // a running erase hears only suspend, resume and the 00F0 reset
            if (flash_dq_out == 16'h00B0 || flash_dq_out == 16'h0030)
                susp = flash_dq_out == 16'h00B0;
        end else if (!is_unl) begin
            erase = flash_dq_out == 16'h0030;
            win = erase ? WIN_RD : 0;
            busy = BUSY_RD;
            abort = cfg_abort;
            tout = cfg_tout;
            last_wr = flash_dq_out;
            sect = flash_addr[19:16];
        end
        armed = 0;
    end
    // the 1 ns settle lets the address land before it is looked at
    always @(negedge flash_oe_n) begin
        #1;
        if (busy == 0 || (susp && flash_addr[19:16] != sect)) rd_word = last_wr;
        else rd_word = {8'h00, erase ? susp : ~last_wr[7], t1, tout, 1'b0,
                        win == 0, t2, abort, 1'b0};
        if (busy > 0 && !susp) t1 = ~t1;
        if (busy > 0 && erase && flash_addr[19:16] == sect) t2 = ~t2;
        if (win > 0) win--;
        else if (busy > 0 && !abort && !tout && !susp) busy--;
    end
    // no pull on dq: a released bus shows a changed value, not the last word
    assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? rd_word : ~rd_word;
    assign ready_busy_n = busy == 0 || susp;
endmodule // fwsr_flash_model

// ===== testbench/flash_write_status_reporting_tb.sv
`timescale 1ns/10ps
module flash_write_status_reporting_tb;
    import fwsr_pkg::*;
    logic              pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]        paddr = '0;
    logic [31:0]       pwdata = '0, prdata, rd, mask = '0;
    logic              pready, pslverr, irq, err, flash_dq_oe, cfg_abort = 0, cfg_tout = 0;
    logic              flash_ce_n, flash_oe_n, flash_we_n, ready_busy_n, fast = 0;
    logic [ADDR_W-1:0] flash_addr;
    logic [DATA_W-1:0] flash_dq_in, flash_dq_out;
    int                n_fail = 0, checks = 0;

    fwsr_ctrl fwsr_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .irq(irq), .flash_addr(flash_addr), .flash_dq_in(flash_dq_in),
        .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
        .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .ready_busy_n(ready_busy_n));
    fwsr_flash_model fwsr_flash_model_inst (.flash_addr(flash_addr),
        .flash_dq_out(flash_dq_out), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
        .flash_we_n(flash_we_n), .cfg_abort(cfg_abort), .cfg_tout(cfg_tout),
        .flash_dq_in(flash_dq_in), .ready_busy_n(ready_busy_n));

    initial forever #12.5 pclk = ~pclk;
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_fail++;
            end_of_test();
        end
        rd = prdata; err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    // start an operation, wait for idle, then judge and clear its events
    task automatic do_op(input logic [2:0] op, input logic [19:0] a, input logic [15:0] d,
                         input logic [31:0] exp);
        int n;
        apb(1, OFS_ADDR, {12'h000, a});
        apb(1, OFS_WDATA, {16'h0000, d});
        apb(1, OFS_CTRL, {23'h00_0000, fast, 5'h00, op});
        n = 0;
        do begin
            apb(0, OFS_STATE, '0);
            n++;
        end while (rd[0] !== 1'b0 && n < 400);
        if (n >= 400) begin
            n_fail++;
            end_of_test();
        end
        apb(0, OFS_INT_STAT, '0);
        chk("int_stat", rd, exp);
        chk("irq", {31'h0, irq}, {31'h0, |(exp & mask)});
        apb(1, OFS_INT_STAT, 32'h0000_001F);
        @(posedge pclk);
        chk("irq_clear", {31'h0, irq}, 32'h0000_0000);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic s_regs();
        apb(1, OFS_INT_MASK, '0);
        apb(0, OFS_INT_MASK, '0);
        chk("int_mask", rd, 32'h0000_0000);
        apb(0, OFS_STATE, '0);
        chk("state", rd, 32'h0000_0002);
        apb(0, 8'h1C, '0);
        chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
        do_op(3'h6, 20'h0_0000, 16'h0000, 32'h0000_0002);
    endtask
    task automatic s_prog();
        do_op(OP_WRITE, 20'h0_0100, 16'h0080, 32'h0000_0001);
        do_op(OP_READ, 20'h0_0100, 16'h0000, 32'h0000_0001);
        apb(0, OFS_RDATA, '0);
        chk("prog_status", rd, 32'h0000_0008);
        apb(0, OFS_STATE, '0);
        chk("busy_pin", rd, 32'h0000_0000);
        do_op(OP_POLL, 20'h0_0100, 16'h0000, 32'h0000_0001);
        apb(0, OFS_STATE, '0);
        chk("ready_pin", rd & 32'h0000_0007, 32'h0000_0002);
    endtask
    task automatic s_abort();
        mask = 32'h0000_0004;
        apb(1, OFS_INT_MASK, mask);
        cfg_abort <= 1;
        do_op(OP_WRITE, 20'h0_0200, 16'h1234, 32'h0000_0001);
        cfg_abort <= 0;
        do_op(OP_POLL, 20'h0_0200, 16'h0000, 32'h0000_0004);
        do_op(OP_ABORT_RST, 20'h0_0200, 16'h0000, 32'h0000_0001);
        do_op(OP_READ, 20'h0_0200, 16'h0000, 32'h0000_0001);
        apb(0, OFS_RDATA, '0);
        chk("array_after_abort", rd, 32'h0000_1234);
    endtask
    task automatic s_tout();
        cfg_tout <= 1;
        do_op(OP_WRITE, 20'h0_0300, 16'h0000, 32'h0000_0001);
        cfg_tout <= 0;
        do_op(OP_POLL, 20'h0_0300, 16'h0000, 32'h0000_0002);
        apb(0, OFS_RDATA, '0);
        chk("timeout_flag", {31'h0, rd[BIT_TIMEOUT_FLAG]}, 32'h0000_0001);
        do_op(OP_ABORT_RST, 20'h0_0300, 16'h0000, 32'h0000_0001);
    endtask
    task automatic s_erase();
        do_op(OP_WRITE, 20'h1_0000, 16'h0030, 32'h0000_0001);
        do_op(OP_ACCEPT, 20'h1_0000, 16'h0000, 32'h0000_0001);
        do_op(OP_SECT_ADD, 20'h1_0000, 16'h0030, 32'h0000_0001);
        fast = 1;
        do_op(OP_SECT_ADD, 20'h1_0000, 16'h0030, 32'h0000_0001);
        fast = 0;
        repeat (6) do_op(OP_READ, 20'h1_0000, 16'h0000, 32'h0000_0001);
        apb(0, OFS_RDATA, '0);
        chk("window_restart", rd & 32'h0000_0008, 32'h0000_0000);
        do_op(OP_READ, 20'h1_0000, 16'h0000, 32'h0000_0001);
        apb(0, OFS_RDATA, '0);
        chk("erase_status", rd & 32'h0000_0088, 32'h0000_0008);
        apb(0, OFS_STATE, '0);
        chk("erase_busy_pin", rd & 32'h0000_0003, 32'h0000_0000);
        do_op(OP_WRITE, 20'h1_0000, 16'h00B0, 32'h0000_0001);
        do_op(OP_POLL, 20'h1_0000, 16'h0000, 32'h0000_0001);
        apb(0, OFS_RDATA, '0);
        chk("susp_poll", rd & 32'h0000_0080, 32'h0000_0080);
        apb(0, OFS_STATE, '0);
        chk("susp_state", rd & 32'h0000_0007, 32'h0000_0006);
        do_op(OP_WRITE, 20'h1_0000, 16'h0030, 32'h0000_0001);
        do_op(OP_SECT_ADD, 20'h1_0000, 16'h0030, 32'h0000_0010);
        do_op(OP_POLL, 20'h1_0000, 16'h0000, 32'h0000_0001);
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        s_regs();
        s_prog();
        s_abort();
        s_tout();
        s_erase();
        end_of_test();
    end
endmodule // flash_write_status_reporting_tb
